// File: hdl/wdg_pkg.sv
// Overview of operation
// RL1 - reset cause register bits 7:4 always read back as zero
// RL2 - watchdog reset sets cause bit 3; power-on or written zero clears it
// RL3 - brown-out reset sets cause bit 2; power-on or written zero clears it
// RL4 - pin reset sets cause bit 1; power-on or written zero clears it
// RL5 - power-on sets cause bit 0; only a written zero clears it
// RL6 - time-out in interrupt mode sets bit 7; vector or written one clears
// RL7 - interrupt requested only while flag, its enable and global enable set
// RL8 - time-out with both enables set clears interrupt enable; next resets
// RL9 - enables select stopped, interrupt, reset or interrupt-then-reset mode on time-out
// RL10 - change unlock bit 4 clears itself four clock cycles after set
// RL11 - enable clears only while unlocked; unlock by writing both ones
// RL12 - new time-out selection accepted only while change unlock is set
// RL13 - always-on fuse makes every disable attempt ineffective
// RL14 - at lower level enable reads one while watchdog cause flag is set
// RL15 - selection codes 0 to 9 give 2048 doubling up to 1048576 ticks
// RL16 - reserved selection codes still give a legal time-out length
// RL17 - software should read then clear cause flags early after start-up
// RL18 - every reset source restarts execution at program address zero
// RL19 - writing one to enable turns the watchdog on at once
// RL20 - counter advances on a 128 kHz tick independent of core timing; here the tick is sys_clk divided by TICK_DIV
// RL21 - counter restarts on clear instruction, when disabled, on chip reset
// RL22 - with always-on fuse the enable bit always reads back as one
// RL23 - time-out in reset mode gives a one system clock reset pulse
// RL24 - events from outside the clock domain pass synchronisers first
// RL25 - reserved selection codes use the shortest time-out of 2048 ticks
package wdg_pkg;
    // bus and register map
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_INDEX = 8'h21;
    localparam logic [7:0] CAUSE_INDEX = 8'h22;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
    localparam logic [ADDR_W-1:0] CAUSE_ADDR = {CAUSE_INDEX, 2'b00};
    // control register fields
    localparam int CTL_IRQ_FLAG = 7;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_SEL3 = 5;
    localparam int CTL_UNLOCK = 4;
    localparam int CTL_EN = 3;
    localparam int CTL_SEL_HI = 2;
    localparam int CTL_SEL_LO = 0;
    // reset cause register fields
    localparam int CAUSE_DOG = 3;
    localparam int CAUSE_BROWN = 2;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_PWR = 0;
    localparam int CAUSE_W = 4;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 4'h1;
    localparam logic [CAUSE_W-1:0] CAUSE_CLEAR = 4'h0;
    // timing
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0] UNLOCK_LAST = 3'h1;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam int BASE_TIMEOUT = 2048;
    localparam int TIMEOUT_W = 21;
    localparam int SYS_CLK_HZ = 10000000;
    localparam int SLOW_OSC_HZ = 128000;
    localparam int TICK_DIV = SYS_CLK_HZ / SLOW_OSC_HZ;
    localparam int DIV_W = 8;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // bus handshake states
    typedef enum logic [1:0] {
        WDG_BUS_IDLE = 2'b00,
        WDG_BUS_ACK = 2'b01
    } wdg_bus_t;
endpackage

// File: hdl/wdg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } wdg_sync_t;

    wdg_sync_t s_reg;
    wdg_sync_t s_next;

    // two flops, the first read only by the second
    always_comb begin
        s_next = s_reg;
        s_next.stage1 = async_in;
        s_next.stage2 = s_reg.stage1; // RL24
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stage2;
endmodule
`default_nettype wire

// File: hdl/wdg_timeout.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_timeout
    import wdg_pkg::*;
#(
    parameter int TICKS = TICK_DIV,
    parameter int BASE = BASE_TIMEOUT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic run,
    input wire logic [3:0] sel,
    output logic timeout
);
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [TIMEOUT_W-1:0] cnt;
        logic timeout;
    } wdg_tmo_t;

    wdg_tmo_t s_reg;
    wdg_tmo_t s_next;
    logic tick;

    // time-out length in slow ticks for a selection code
    function automatic logic [TIMEOUT_W-1:0] limit(input logic [3:0] code);
        logic [TIMEOUT_W-1:0] base_w;
        base_w = TIMEOUT_W'(BASE);
        if (code > SEL_MAX) begin
            limit = base_w; // RL16 RL25
        end else begin
            limit = base_w << code; // RL15
        end
    endfunction

    // slow oscillator tick as an enable pulse
    assign tick = (s_reg.div == DIV_W'(TICKS - 1)); // RL20

    always_comb begin
        s_next = s_reg;
        s_next.timeout = 1'b0;
        s_next.div = tick ? '0 : s_reg.div + 1'b1;
        if (clear || !run) begin
            s_next.cnt = '0; // RL21
        end else if (tick) begin
            if (s_reg.cnt == limit(sel) - 1'b1) begin
                s_next.cnt = '0;
                s_next.timeout = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign timeout = s_reg.timeout;
endmodule
`default_nettype wire

// File: hdl/wdg_watchdog.sv
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog #(
    parameter int TICKS = wdg_pkg::TICK_DIV,
    parameter int BASE = wdg_pkg::BASE_TIMEOUT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [wdg_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [wdg_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [wdg_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic dog_clear_instruction,
    input wire logic pin_reset_event,
    input wire logic brownout_event,
    input wire logic always_on_fuse,
    output logic timeout_irq_req,
    output logic dog_reset_pulse,
    output logic [15:0] restart_vector
);
    import wdg_pkg::*;

    typedef struct packed {
        wdg_bus_t bus;
        logic wait_req;
        logic [DATA_W-1:0] rdata;
        logic irq_flag;
        logic irq_en;
        logic en;
        logic [3:0] sel;
        logic unlock;
        logic [2:0] unlock_cnt;
        logic [CAUSE_W-1:0] cause;
        logic pin_prev;
        logic brown_prev;
        logic irq_req;
        logic rst_pulse;
        logic [15:0] vector;
    } wdg_state_t;

    wdg_state_t s_reg;
    wdg_state_t s_next;
    logic [2:0] pins_sync;
    logic pin_lvl;
    logic brown_lvl;
    logic fuse;
    logic eff_en;
    logic run;
    logic tmo;
    logic pin_rise;
    logic brown_rise;
    logic chip_rst;
    logic cnt_clear;
    logic [7:0] wd;

    // outside pins pass two flops first
    wdg_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in({always_on_fuse, brownout_event, pin_reset_event}),
        .sync_out(pins_sync)
    ); // RL24

    assign pin_lvl = pins_sync[0];
    assign brown_lvl = pins_sync[1];
    assign fuse = pins_sync[2];

    // reset sources seen as rising edges of the synchronised levels
    assign pin_rise = pin_lvl && !s_reg.pin_prev;
    assign brown_rise = brown_lvl && !s_reg.brown_prev;
    // own reset pulse acts as a chip reset one cycle later
    assign chip_rst = pin_rise || brown_rise || s_reg.rst_pulse;

    // effective enable: fuse forces on, cause flag holds on
    assign eff_en = s_reg.en || fuse || s_reg.cause[CAUSE_DOG]; // RL14 RL22
    assign run = eff_en || s_reg.irq_en; // RL9
    assign cnt_clear = dog_clear_instruction || chip_rst; // RL21
    assign wd = writedata[7:0];

    wdg_timeout #(
        .TICKS(TICKS),
        .BASE(BASE)
    ) u_timeout (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clear(cnt_clear),
        .run(run),
        .sel(s_reg.sel),
        .timeout(tmo)
    );

    // control register read view
    function automatic logic [7:0] ctrl_view(input wdg_state_t st,
                                             input logic en_now);
        logic [7:0] v;
        v = 8'h00;
        v[CTL_IRQ_FLAG] = st.irq_flag;
        v[CTL_IRQ_EN] = st.irq_en;
        v[CTL_SEL3] = st.sel[3];
        v[CTL_UNLOCK] = st.unlock;
        v[CTL_EN] = en_now;
        v[CTL_SEL_HI:CTL_SEL_LO] = st.sel[2:0];
        ctrl_view = v;
    endfunction

    // next state of bus, control, cause flags and outputs
    always_comb begin
        s_next = s_reg;
        s_next.pin_prev = pin_lvl;
        s_next.brown_prev = brown_lvl;
        s_next.rst_pulse = 1'b0;

        // bus handshake: one wait cycle, answer on the second
        case (s_reg.bus)
            WDG_BUS_IDLE: begin
                s_next.wait_req = 1'b1;
                if (read || write) begin
                    s_next.bus = WDG_BUS_ACK;
                    s_next.wait_req = 1'b0;
                    if (address == CTRL_ADDR) begin
                        s_next.rdata = {24'h000000,
                                        ctrl_view(s_reg, eff_en)};
                    end else if (address == CAUSE_ADDR) begin
                        s_next.rdata = {28'h0000000, s_reg.cause}; // RL1
                    end else begin
                        s_next.rdata = '0;
                    end
                end
            end
            WDG_BUS_ACK: begin
                s_next.bus = WDG_BUS_IDLE;
                s_next.wait_req = 1'b1;
            end
            default: begin
                s_next.bus = WDG_BUS_IDLE;
                s_next.wait_req = 1'b1;
            end
        endcase

        // unlock window counts down and closes itself
        if (s_reg.unlock) begin
            if (s_reg.unlock_cnt == UNLOCK_LAST) begin
                s_next.unlock = 1'b0; // RL10
                s_next.unlock_cnt = '0;
            end else begin
                s_next.unlock_cnt = s_reg.unlock_cnt - 1'b1;
            end
        end

        // interrupt vector taken clears the time-out flag
        if (irq_vector_taken) begin
            s_next.irq_flag = 1'b0; // RL6
        end

        // register writes take effect at the answering edge
        if (s_reg.bus == WDG_BUS_ACK && write && byteenable[0]) begin
            if (address == CTRL_ADDR) begin
                if (wd[CTL_IRQ_FLAG]) begin
                    s_next.irq_flag = 1'b0; // RL6
                end
                s_next.irq_en = wd[CTL_IRQ_EN];
                if (s_reg.unlock) begin
                    s_next.sel = {wd[CTL_SEL3],
                                  wd[CTL_SEL_HI:CTL_SEL_LO]}; // RL12
                end
                if (wd[CTL_EN]) begin
                    s_next.en = 1'b1; // RL19
                end else if (s_reg.unlock && !fuse) begin
                    s_next.en = 1'b0; // RL11 RL13
                end
                if (wd[CTL_UNLOCK] && wd[CTL_EN]) begin
                    s_next.unlock = 1'b1; // RL11
                    s_next.unlock_cnt = UNLOCK_CYCLES;
                end
            end else if (address == CAUSE_ADDR) begin
                // a written zero clears, a written one keeps
                s_next.cause = s_reg.cause & wd[CAUSE_W-1:0]; // RL2 RL3
            end
        end

        // time-out action by mode; hardware set wins over vector and write clears
        if (tmo) begin
            if (s_reg.irq_en) begin
                s_next.irq_flag = 1'b1; // RL6 RL9
                if (eff_en) begin
                    s_next.irq_en = 1'b0; // RL8
                end
            end else if (eff_en) begin
                s_next.rst_pulse = 1'b1; // RL9 RL23
            end
        end

        // chip reset from pin, brown-out or own pulse
        if (chip_rst) begin
            s_next.irq_flag = 1'b0;
            s_next.irq_en = 1'b0;
            s_next.en = 1'b0;
            s_next.sel = SEL_RESET;
            s_next.unlock = 1'b0;
            s_next.unlock_cnt = '0;
            s_next.vector = RESET_VECTOR; // RL18
            if (s_reg.rst_pulse) begin
                s_next.cause[CAUSE_DOG] = 1'b1; // RL2
            end
            if (brown_rise) begin
                s_next.cause[CAUSE_BROWN] = 1'b1; // RL3
            end
            if (pin_rise) begin
                s_next.cause[CAUSE_PIN] = 1'b1; // RL4
            end
        end

        // interrupt request gated by both enables
        s_next.irq_req = s_next.irq_flag && s_next.irq_en
                         && global_irq_enable; // RL7
    end

    // power-on reset sets only the power-up flag
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.bus <= WDG_BUS_IDLE;
            s_reg.wait_req <= 1'b1;
            s_reg.sel <= SEL_RESET;
            s_reg.cause <= CAUSE_RESET; // RL2 RL3 RL4 RL5
            s_reg.vector <= RESET_VECTOR; // RL18
        end else begin
            s_reg <= s_next;
        end
    end

    assign readdata = s_reg.rdata;
    assign waitrequest = s_reg.wait_req;
    assign timeout_irq_req = s_reg.irq_req;
    assign dog_reset_pulse = s_reg.rst_pulse;
    assign restart_vector = s_reg.vector;
endmodule
`default_nettype wire

// File: dv/wdg_watchdog_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_monitor #(
    parameter int TICKS = wdg_pkg::TICK_DIV,
    parameter int BASE = wdg_pkg::BASE_TIMEOUT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [wdg_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [wdg_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [wdg_pkg::DATA_W-1:0] readdata,
    input wire logic waitrequest,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic dog_clear_instruction,
    input wire logic pin_reset_event,
    input wire logic brownout_event,
    input wire logic always_on_fuse,
    input wire logic timeout_irq_req,
    input wire logic dog_reset_pulse,
    input wire logic [15:0] restart_vector
);
    import wdg_pkg::*;
    logic rd_ans;
    // a read answered in this cycle
    assign rd_ans = read && !waitrequest;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // request taken, then exactly one answer cycle
    sequence s_take;
        (read || write) && waitrequest;
    endsequence
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    a_bus_answer: assert property (s_take |=> s_answer)
        else $error("bus answer not a single cycle");
    a_upper_zero: assert property (rd_ans |-> readdata[31:8] == 24'h0)
        else $error("read data above low byte set");
    a_cause_high: assert property (
        rd_ans && address == CAUSE_ADDR |-> readdata[7:4] == 4'h0)
        else $error("cause upper bits set");
    a_unmapped_zero: assert property (rd_ans && address != CTRL_ADDR
        && address != CAUSE_ADDR |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    // fuse passes a two-flop synchroniser first
    a_fuse_enable: assert property (
        rd_ans && address == CTRL_ADDR && $past(always_on_fuse, 3)
        |-> readdata[CTL_EN])
        else $error("enable reads zero with fuse set");
    a_vector_zero: assert property (
        restart_vector == RESET_VECTOR)
        else $error("restart vector not zero");
    a_pulse_single: assert property (
        dog_reset_pulse |=> !dog_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_irq_global: assert property (
        !global_irq_enable |=> !timeout_irq_req)
        else $error("request without global enable");
    a_vector_clears: assert property (
        irq_vector_taken |-> ##3 !timeout_irq_req)
        else $error("request left after vector taken");
endmodule
bind wdg_watchdog wdg_monitor #(.TICKS(TICKS), .BASE(BASE)) i_wdg_monitor (
    .sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken),
    .dog_clear_instruction(dog_clear_instruction),
    .pin_reset_event(pin_reset_event), .brownout_event(brownout_event),
    .always_on_fuse(always_on_fuse), .timeout_irq_req(timeout_irq_req),
    .dog_reset_pulse(dog_reset_pulse), .restart_vector(restart_vector)
);
`default_nettype wire

// File: dv/wdg_watchdog_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog_tb_top;
    import wdg_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [3:0] byteenable = 4'hF;
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    logic global_irq_enable = 1'b0;
    logic irq_vector_taken = 1'b0;
    logic dog_clear_instruction = 1'b0;
    logic pin_reset_event = 1'b0;
    logic brownout_event = 1'b0;
    logic always_on_fuse = 1'b0;
    logic timeout_irq_req;
    logic dog_reset_pulse;
    logic [15:0] restart_vector;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    // short tick and base so time-outs take tens of cycles
    wdg_watchdog #(.TICKS(2), .BASE(4)) i_wdg_watchdog (
        .sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .global_irq_enable(global_irq_enable),
        .irq_vector_taken(irq_vector_taken),
        .dog_clear_instruction(dog_clear_instruction),
        .pin_reset_event(pin_reset_event), .brownout_event(brownout_event),
        .always_on_fuse(always_on_fuse), .timeout_irq_req(timeout_irq_req),
        .dog_reset_pulse(dog_reset_pulse), .restart_vector(restart_vector)
    );
    // 10 MHz clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [7:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, e);
    endtask
    // wait for reset pulse or interrupt request, bounded
    task automatic wait_for(input bit dog, input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((dog ? dog_reset_pulse : timeout_irq_req) !== 1'b1
            && n < lim);
    endtask
    task automatic evt(input bit brown);
        @(posedge sys_clk);
        pin_reset_event <= !brown;
        brownout_event <= brown;
        repeat (4) @(posedge sys_clk);
        pin_reset_event <= 1'b0;
        brownout_event <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic do_reset(input logic fuse);
        @(posedge sys_clk);
        rstn <= 1'b0;
        always_on_fuse <= fuse;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        // fuse synchroniser is held clear in reset, let it fill
        repeat (3) @(posedge sys_clk);
    endtask
    // timed disable attempt
    task automatic unlock_off();
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h00);
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic t_cause();
        rd(CAUSE_ADDR, 32'h01);
        rd(CTRL_ADDR, 32'h00);
        rd(10'h3F0, 32'h00);
        evt(1'b0);
        rd(CAUSE_ADDR, 32'h03);
        evt(1'b1);
        rd(CAUSE_ADDR, 32'h07);
        check({16'h0, restart_vector}, 32'h0);
        byteenable <= 4'h0;
        wr(CAUSE_ADDR, 8'h00);
        byteenable <= 4'hF;
        wr(CAUSE_ADDR, 8'hFE);
        rd(CAUSE_ADDR, 32'h06);
        wr(CAUSE_ADDR, 8'h00);
        rd(CAUSE_ADDR, 32'h00);
    endtask
    task automatic t_irq();
        int n;
        global_irq_enable <= 1'b1;
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h43);
        wait_for(1'b0, 200, n);
        check({31'h0, n > 40 && n < 80}, 32'h1);
        rd(CTRL_ADDR, 32'hC3);
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check({31'h0, timeout_irq_req}, 32'h0);
        wr(CTRL_ADDR, 8'hC3);
        rd(CTRL_ADDR, 32'h43);
        global_irq_enable <= 1'b1;
        wait_for(1'b0, 200, n);
        check({31'h0, timeout_irq_req}, 32'h1);
        irq_vector_taken <= 1'b1;
        @(posedge sys_clk);
        irq_vector_taken <= 1'b0;
        rd(CTRL_ADDR, 32'h43);
    endtask
    task automatic t_dog();
        int n;
        wr(CTRL_ADDR, 8'h4B);
        rd(CTRL_ADDR, 32'h4B);
        // flag set and enable clear land together, so no request rises
        repeat (60) @(posedge sys_clk);
        check({31'h0, timeout_irq_req}, 32'h0);
        rd(CTRL_ADDR, 32'h8B);
        wr(CTRL_ADDR, 8'h8B);
        wait_for(1'b1, 200, n);
        check({31'h0, dog_reset_pulse}, 32'h1);
        dog_clear_instruction <= 1'b1;
        rd(CAUSE_ADDR, 32'h08);
        rd(CTRL_ADDR, 32'h08);
        unlock_off();
        rd(CTRL_ADDR, 32'h08);
        wr(CAUSE_ADDR, 8'h00);
        unlock_off();
        rd(CTRL_ADDR, 32'h00);
        dog_clear_instruction <= 1'b0;
        wait_for(1'b1, 100, n);
        check({31'h0, dog_reset_pulse}, 32'h0);
    endtask
    task automatic t_fuse();
        int n;
        dog_clear_instruction <= 1'b1;
        do_reset(1'b1);
        rd(CTRL_ADDR, 32'h08);
        wr(CTRL_ADDR, 8'h18);
        rd(CTRL_ADDR, 32'h18);
        repeat (4) @(posedge sys_clk);
        rd(CTRL_ADDR, 32'h08);
        unlock_off();
        rd(CTRL_ADDR, 32'h08);
        wr(CTRL_ADDR, 8'h18);
        wr(CTRL_ADDR, 8'h2F);
        dog_clear_instruction <= 1'b0;
        wait_for(1'b1, 100, n);
        check({31'h0, n < 24}, 32'h1);
    endtask
    // main sequence
    initial begin
        do_reset(1'b0);
        t_cause();
        t_irq();
        t_dog();
        t_fuse();
        conclude();
    end
endmodule
`default_nettype wire
